/* File: rtl/dsm_core_supervisor.sv */
// memories, program sequencing, checksum and runaway supervision with auto mute
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module dsm_core_supervisor
  import dsm_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               frame_start,
  input  wire logic [AUDIO_W-1:0] audio_in,
  output logic      [AUDIO_W-1:0] audio_out,
  output logic                    core_mute,
  output logic                    core_busy,
  output dsm_err_s                err_flags,
  output logic      [13:0]        nonmodulo_start
);
  // ==========================================================
  // reset release through two flops
  logic rst_s1_ff;
  logic rst_n;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n     <= rst_s1_ff;
    end
  end

  // ==========================================================
  // storage; memories are not reset so contents survive frames
  logic [INSTR_W-1:0] instr_mem [INSTR_DEPTH];
  logic [DATA_W-1:0]  coef_mem  [COEF_DEPTH];
  logic [DATA_W-1:0]  samp_mem  [SAMP_DEPTH];
  logic [31:0]        crc_ideal_ff, wd_limit_ff, code_ff, frame_code_ff, cyc_ff;
  logic               crc_en_ff, wd_en_ff, run_ff, pready_ff, slverr_ff;
  logic [1:0]         mute_ctl_ff;
  logic [13:0]        nonmod_ff;
  logic [10:0]        instr_hi_ff;
  logic [15:0]        peak_ff;
  logic [31:0]        prdata_ff;
  logic [11:0]        pc_ff, crc_frm_ff;
  dsm_core_e          state_ff;
  dsm_err_s           err_ff;
  logic               mute_ff;
  logic [AUDIO_W-1:0] audio_ff;

  function automatic logic in_rgn(input logic [15:0] a, input logic [15:0] b, input int d);
    return (int'(a) >= int'(b)) && (int'(a) < int'(b) + d);
  endfunction

  function automatic logic [31:0] fold(input logic [31:0] c, input logic [INSTR_W-1:0] w);
    return {c[30:0], c[31]} ^ w[31:0] ^ {21'h0, w[42:32]};
  endfunction

  // ==========================================================
  // bus decode; the word index is the address divided by four
  wire [15:0] ix       = paddr[17:2];
  wire        hit_coef = in_rgn(ix, IX_COEF, COEF_DEPTH);
  wire        hit_ins  = in_rgn(ix, IX_INSTR, INSTR_DEPTH);
  wire        hit_samp = in_rgn(ix, IX_SAMP, SAMP_DEPTH);
  wire [11:0] mw_ix    = ix[11:0];
  wire [12:0] sw_ix    = ix[12:0];
  wire        hit_reg  = ix == IX_CRC_HI || ix == IX_CRC_LO || ix == IX_CRC_EN ||
                         ix == IX_WD_EN || ix == IX_WD_HI || ix == IX_WD_LO ||
                         ix == IX_NONMOD || ix == IX_CRC_ERR || ix == IX_WD_ERR ||
                         ix == IX_MUTE || ix == IX_RUN || ix == IX_PEAK ||
                         ix == IX_INSTR_HI;
  wire        hit      = hit_coef | hit_ins | hit_samp | hit_reg;
  wire        acc      = ce & psel & penable;
  wire        wr       = acc & pwrite & pready_ff & ~slverr_ff;
  wire [INSTR_W-1:0] ins_rd = instr_mem[mw_ix];
  // reserved bits of every control word read as zero
  wire [31:0] rd_data  =
    hit_coef           ? {4'h0, coef_mem[mw_ix]} :
    hit_samp           ? {4'h0, samp_mem[sw_ix]} :
    hit_ins            ? ins_rd[31:0] :
    ix == IX_CRC_HI    ? {16'h0, crc_ideal_ff[31:16]} :
    ix == IX_CRC_LO    ? {16'h0, crc_ideal_ff[15:0]} :
    ix == IX_CRC_EN    ? {31'h0, crc_en_ff} :
    ix == IX_WD_EN     ? {31'h0, wd_en_ff} :
    ix == IX_WD_HI     ? {16'h0, wd_limit_ff[31:16]} :
    ix == IX_WD_LO     ? {16'h0, wd_limit_ff[15:0]} :
    ix == IX_NONMOD    ? {18'h0, nonmod_ff} :
    ix == IX_CRC_ERR   ? {31'h0, err_ff.crc} :
    ix == IX_WD_ERR    ? {31'h0, err_ff.wd} :
    ix == IX_MUTE      ? {30'h0, mute_ctl_ff} :
    ix == IX_RUN       ? {31'h0, run_ff} :
    ix == IX_PEAK      ? {16'h0, peak_ff} :
    ix == IX_INSTR_HI  ? {21'h0, instr_hi_ff} : 32'h0;

  // ==========================================================
  // apb: one wait state, answer registered, write lands at the ready edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (ce) begin
      pready_ff <= acc & ~pready_ff;
      slverr_ff <= acc & ~pready_ff & ~hit;
      if (acc && !pready_ff) prdata_ff <= (hit && !pwrite) ? rd_data : 32'h0;
    end
  end

  // control words; only the documented bits are stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc_ideal_ff <= 32'h0;
      wd_limit_ff  <= 32'h0;
      crc_en_ff    <= 1'b0;
      wd_en_ff     <= 1'b0;
      run_ff       <= 1'b0;
      mute_ctl_ff  <= MUTE_RST;
      nonmod_ff    <= NONMOD_RST;
      instr_hi_ff  <= 11'h0;
    end else if (wr) begin
      if (ix == IX_CRC_HI) crc_ideal_ff[31:16] <= pwdata[15:0];
      if (ix == IX_CRC_LO) crc_ideal_ff[15:0] <= pwdata[15:0];
      if (ix == IX_WD_HI) wd_limit_ff[31:16] <= pwdata[15:0];
      if (ix == IX_WD_LO) wd_limit_ff[15:0] <= pwdata[15:0];
      if (ix == IX_CRC_EN) crc_en_ff <= pwdata[0];
      if (ix == IX_WD_EN) wd_en_ff <= pwdata[0];
      if (ix == IX_RUN) run_ff <= pwdata[0];
      if (ix == IX_MUTE) mute_ctl_ff <= pwdata[1:0];
      if (ix == IX_NONMOD) nonmod_ff <= pwdata[13:0];
      if (ix == IX_INSTR_HI) instr_hi_ff <= pwdata[10:0];
    end else if (acc && !pready_ff && !pwrite && hit_ins) begin
      instr_hi_ff <= ins_rd[42:32];      // upper bits staged for the next read
    end
  end

  // memory writes; an instruction takes the staged upper 11 bits
  always_ff @(posedge clock) begin
    if (wr && hit_ins) instr_mem[mw_ix] <= {instr_hi_ff, pwdata};
    if (wr && hit_coef) coef_mem[mw_ix] <= pwdata[27:0];
    if (wr && hit_samp) samp_mem[sw_ix] <= pwdata[27:0];
  end

  // ==========================================================
  // program sequencing; a start pulse mid-program restarts it (audio corrupt)
  wire [INSTR_W-1:0] fetch  = instr_mem[pc_ff];
  wire               is_end = fetch[OPC_MSB:OPC_LSB] == OPC_JMP_ST;
  wire               go     = ce & frame_start & run_ff;
  wire               busy   = state_ff == DSM_RUN;
  wire [15:0]        cyc_sat = (cyc_ff[31:16] != 16'h0) ? 16'hFFFF : cyc_ff[15:0];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= DSM_IDLE;
      pc_ff    <= PC_START;
      cyc_ff   <= 32'h0;
      peak_ff  <= 16'h0;
    end else if (ce) begin
      if (frame_start) peak_ff <= cyc_sat;
      case (state_ff)
        DSM_IDLE: begin
          if (go) begin
            state_ff <= DSM_RUN;
            pc_ff    <= PC_START;
            cyc_ff   <= 32'h0;
          end
        end
        DSM_RUN: begin
          if (go) begin
            pc_ff  <= PC_START;
            cyc_ff <= 32'h0;
          end else if (is_end) begin
            pc_ff    <= PC_START;
            state_ff <= DSM_IDLE;
            cyc_ff   <= cyc_ff + 32'h1;
          end else begin
            pc_ff  <= pc_ff + 12'h1;
            cyc_ff <= cyc_ff + 32'h1;
          end
        end
        default: state_ff <= DSM_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checksum over fetched words, compared once every 4096 frames
  wire crc_bad = frame_start & (crc_frm_ff == CRC_FRM_END) & (frame_code_ff != crc_ideal_ff);
  wire wd_hit  = wd_en_ff & busy & (cyc_ff == wd_limit_ff);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      code_ff       <= 32'h0;
      frame_code_ff <= 32'h0;
      crc_frm_ff    <= 12'h0;
      err_ff        <= '0;
    end else if (ce) begin
      if (go) code_ff <= 32'h0;
      else if (busy) code_ff <= fold(code_ff, fetch);
      if (busy && is_end && !go) frame_code_ff <= fold(code_ff, fetch);
      if (frame_start) crc_frm_ff <= crc_frm_ff + 12'h1;
      // flags are sticky; clearing the enable is the only clear besides reset
      err_ff.crc <= crc_en_ff & (err_ff.crc | crc_bad);
      err_ff.wd  <= wd_en_ff & (err_ff.wd | wd_hit);
    end
  end

  // ==========================================================
  // auto mute and output slew; slewing avoids a dc step into the speakers
  wire nxt_mute = ~run_ff | (mute_ctl_ff[MUTE_CRC_B] & err_ff.crc)
                          | (mute_ctl_ff[MUTE_WD_B] & err_ff.wd);
  wire               neg  = audio_ff[AUDIO_W-1];
  wire [AUDIO_W-1:0] mag  = neg ? (~audio_ff + 24'h1) : audio_ff;
  wire [AUDIO_W-1:0] nmag = (mag > SLEW_STEP) ? (mag - SLEW_STEP) : 24'h0;
  wire [AUDIO_W-1:0] nxt_audio = neg ? (~nmag + 24'h1) : nmag;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mute_ff  <= 1'b1;
      audio_ff <= 24'h0;
    end else if (ce) begin
      mute_ff  <= nxt_mute;
      audio_ff <= mute_ff ? nxt_audio : audio_in;
    end
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = slverr_ff;
  assign audio_out       = audio_ff;
  assign core_mute       = mute_ff;
  assign core_busy       = state_ff == DSM_RUN;
  assign err_flags       = err_ff;
  assign nonmodulo_start = nonmod_ff;

  // ==========================================================
  // checks
  property p_mute_crc;
    @(posedge clock) disable iff (!rst_n) ce && err_ff.crc && mute_ctl_ff[MUTE_CRC_B] |=> mute_ff;
  endproperty
  a_mute_crc: assert property (p_mute_crc) else $error("crc error did not mute");
  property p_mute_wd;
    @(posedge clock) disable iff (!rst_n) ce && err_ff.wd && mute_ctl_ff[MUTE_WD_B] |=> mute_ff;
  endproperty
  a_mute_wd: assert property (p_mute_wd) else $error("watchdog error did not mute");
  property p_rst_val;
    @(posedge clock) rst_n && !$past(rst_n) |-> mute_ctl_ff == MUTE_RST && nonmod_ff == NONMOD_RST;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad control reset value");
  property p_peak;
    @(posedge clock) disable iff (!rst_n) ce && frame_start |=> peak_ff == $past(cyc_sat);
  endproperty
  a_peak: assert property (p_peak) else $error("peak not refreshed at start");
  property p_pc_ret;
    @(posedge clock) disable iff (!rst_n)
      ce && busy && is_end && !frame_start |=> pc_ff == PC_START && state_ff == DSM_IDLE;
  endproperty
  a_pc_ret: assert property (p_pc_ret) else $error("no return to start");
  property p_crc_clr;
    @(posedge clock) disable iff (!rst_n) ce && !crc_en_ff |=> !err_ff.crc;
  endproperty
  a_crc_clr: assert property (p_crc_clr) else $error("crc flag not cleared");
  property p_wd_set;
    @(posedge clock) disable iff (!rst_n) ce && wd_en_ff && busy && cyc_ff == wd_limit_ff
      |=> err_ff.wd [*2];
  endproperty
  a_wd_set: assert property (p_wd_set) else $error("runaway not flagged");
  property p_slew;
    @(posedge clock) disable iff (!rst_n) ce && mute_ff && audio_ff != 24'h0
      |=> audio_ff != $past(audio_ff);
  endproperty
  a_slew: assert property (p_slew) else $error("muted output not slewing");
  property p_rsv;
    @(posedge clock) disable iff (!rst_n) pready_ff && ix == IX_MUTE |-> prdata_ff[31:2] == 30'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
endmodule

/* File: shared/dsm_pkg.sv */
// constants, types and register map of the core memory supervisor
package dsm_pkg;
  // ==========================================================
  // bus and memory geometry
  localparam int          ADDR_W      = 18;
  localparam int          INSTR_W     = 43;
  localparam int          DATA_W      = 28;
  localparam int          AUDIO_W     = 24;
  localparam int          INSTR_DEPTH = 4096;
  localparam int          COEF_DEPTH  = 4096;
  localparam int          SAMP_DEPTH  = 8192;
  localparam logic [15:0] IX_COEF     = 16'h0000;
  localparam logic [15:0] IX_INSTR    = 16'h2000;
  localparam logic [15:0] IX_SAMP     = 16'h4000;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [15:0] IX_CRC_HI   = 16'hE200;
  localparam logic [15:0] IX_CRC_LO   = 16'hE201;
  localparam logic [15:0] IX_CRC_EN   = 16'hE202;
  localparam logic [15:0] IX_WD_EN    = 16'hE210;
  localparam logic [15:0] IX_WD_HI    = 16'hE211;
  localparam logic [15:0] IX_WD_LO    = 16'hE212;
  localparam logic [15:0] IX_NONMOD   = 16'hE21F;
  localparam logic [15:0] IX_CRC_ERR  = 16'hE225;
  localparam logic [15:0] IX_WD_ERR   = 16'hE226;
  localparam logic [15:0] IX_MUTE     = 16'hE227;
  localparam logic [15:0] IX_RUN      = 16'hE228;
  localparam logic [15:0] IX_PEAK     = 16'hE229;
  localparam logic [15:0] IX_INSTR_HI = 16'hE300;
  // ==========================================================
  // fields and reset values
  localparam logic [13:0] NONMOD_RST  = 14'h1F00;
  localparam logic [1:0]  MUTE_RST    = 2'h0;
  localparam int          MUTE_CRC_B  = 1;
  localparam int          MUTE_WD_B   = 0;
  localparam logic [11:0] PC_START    = 12'h010;
  localparam int          OPC_MSB     = 42;
  localparam int          OPC_LSB     = 38;
  localparam logic [4:0]  OPC_JMP_ST  = 5'h1F;
  localparam logic [11:0] CRC_FRM_END = 12'hFFF;
  localparam logic [23:0] SLEW_STEP   = 24'h000100;
  // ==========================================================
  // types
  typedef enum logic {DSM_IDLE, DSM_RUN} dsm_core_e;
  typedef struct packed {
    logic crc;
    logic wd;
  } dsm_err_s;
endpackage

/* File: tb/dsm_host_model.sv */
// host controller model: apb master that loads memories and control words
`timescale 1ns/1ps
module dsm_host_model
  import dsm_pkg::*;
(
  input  wire logic              clock,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  // ==========================================================
  // bus idle at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // ==========================================================
  // one transfer; ix is the word index, byte address is four times it
  task automatic xfer(input logic w, input logic [15:0] ix, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    err = pslverr;
    // released lines show garbage so a stale value is never mistaken for data
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~paddr;
    pwdata  <= ~pwdata;
  endtask

  // sample memory zeroed before the core is booted
  task automatic clear_samples();
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < SAMP_DEPTH; i++) xfer(1'b1, IX_SAMP + 16'(i), 32'h0, q, e);
  endtask
endmodule

/* File: tb/dsp_core_memory_supervision_bench.sv */
// self-checking bench of the core memory supervisor with a register model
`timescale 1ns/1ps
module dsp_core_memory_supervision_bench
  import dsm_pkg::*;
;
  logic clock, nrst, frame_start, rnd, ce;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata;
  logic               psel, penable, pwrite, pready, pslverr, core_mute, core_busy;
  logic [AUDIO_W-1:0] audio_in, audio_out, a;
  logic [13:0]        nonmodulo_start;
  dsm_err_s           err_flags;
  logic [31:0]        exp_mem[int];
  logic [31:0]        ihi[int];
  logic [42:0]        prog[$];
  logic [31:0]        q;
  logic               e;
  int                 failures, comparisons, n;

  // ==========================================================
  // clock, audio source and instances
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // random audio while running, a small constant to watch the slew
  always @(posedge clock) audio_in <= rnd ? 24'($urandom) : 24'h000450;

  dsm_host_model u_dsm_host_model (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  dsm_core_supervisor u_dsm_core_supervisor (.clock(clock), .nrst(nrst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_start(frame_start),
    .audio_in(audio_in), .audio_out(audio_out), .core_mute(core_mute),
    .core_busy(core_busy), .err_flags(err_flags), .nonmodulo_start(nonmodulo_start));

  // ==========================================================
  // checking and register model
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // writable bits of each word; read-only flags keep zero
  function automatic logic [31:0] mask(input logic [15:0] ix);
    if (ix < 16'h1000 || (ix >= IX_SAMP && ix < 16'h6000)) return 32'h0FFFFFFF;
    if (ix >= IX_INSTR && ix < 16'h3000) return 32'hFFFFFFFF;
    if (ix == IX_INSTR_HI) return 32'h7FF;
    if (ix == IX_MUTE) return 32'h3;
    if (ix == IX_NONMOD) return 32'h3FFF;
    if (ix inside {IX_CRC_EN, IX_WD_EN, IX_RUN}) return 32'h1;
    if (ix inside {IX_CRC_ERR, IX_WD_ERR}) return 32'h0;
    return 32'hFFFF;
  endfunction

  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    u_dsm_host_model.xfer(1'b1, ix, d, q, e);
    exp_mem[ix] = d & mask(ix);
    if (ix >= IX_INSTR && ix < 16'h3000) ihi[ix] = exp_mem[IX_INSTR_HI];
  endtask

  task automatic rd(input string nm, input logic [15:0] ix);
    u_dsm_host_model.xfer(1'b0, ix, 32'h0, q, e);
    check(nm, q, exp_mem.exists(ix) ? exp_mem[ix] : 32'h0);
    if (ihi.exists(ix)) exp_mem[IX_INSTR_HI] = ihi[ix];
  endtask

  // one frame start pulse, then count busy cycles over a fixed gap
  task automatic frame(input int gap, output int cnt);
    @(posedge clock);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    cnt = 0;
    repeat (gap) begin
      @(posedge clock);
      cnt += int'(core_busy === 1'b1);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // hang guard, sized well past the longest expected run
  initial begin
    #800000;
    failures++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    frame_start = 1'b0;
    rnd = 1'b1;
    ce = 1'b1;
    audio_in = '0;
    void'($urandom(32'h495B990F));
    exp_mem[IX_NONMOD] = {18'h0, NONMOD_RST};
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    check("nonmod_pin", {18'h0, nonmodulo_start}, {18'h0, NONMOD_RST});
    rd("nonmod", IX_NONMOD);
    rd("mute_rst", IX_MUTE);
    wr(IX_MUTE, 32'hFFFF);
    rd("mute_rsv", IX_MUTE);
    wr(IX_CRC_ERR, 32'h1);
    rd("crc_ro", IX_CRC_ERR);
    u_dsm_host_model.xfer(1'b0, 16'hE0C0, 32'h0, q, e);
    check("unmapped_err", {31'h0, e}, 32'h1);
    check("unmapped_data", q, 32'h0);
    u_dsm_host_model.clear_samples();
    rd("samp_clear", IX_SAMP + 16'h0100);
    // application coefficients from 0x0008 upward, plus the memory ends
    wr(16'h0008, $urandom);
    rd("coef_lo", 16'h0008);
    wr(16'h0FFF, $urandom);
    rd("coef_end", 16'h0FFF);
    wr(IX_SAMP + 16'h1FFF, $urandom);
    rd("samp_end", IX_SAMP + 16'h1FFF);
    // four-word program, far under the quad-rate limit; rest left unwritten
    repeat (3) prog.push_back({1'b0, 42'($urandom)});
    prog.push_back({OPC_JMP_ST, 38'($urandom)});
    foreach (prog[i]) begin
      wr(IX_INSTR_HI, {21'h0, prog[i][42:32]});
      wr(IX_INSTR + 16'h0010 + 16'(i), prog[i][31:0]);
    end
    rd("instr_lo", IX_INSTR + 16'h0010);
    rd("instr_hi", IX_INSTR_HI);
    wr(IX_MUTE, 32'h0);
    wr(IX_RUN, 32'h1);
    repeat (3) @(posedge clock);
    #1 a = audio_in;
    @(posedge clock);
    #1 check("audio_pass", {8'h0, audio_out}, {8'h0, a});
    // clock enable low freezes the output stage while the source keeps changing
    @(posedge clock);
    ce <= 1'b0;
    #1 a = audio_out;
    repeat (4) @(posedge clock);
    #1 check("ce_hold", {8'h0, audio_out}, {8'h0, a});
    @(posedge clock);
    ce <= 1'b1;
    frame(40, n);
    frame(40, n);
    check("run_len", n, prog.size());
    exp_mem[IX_PEAK] = prog.size();
    rd("peak", IX_PEAK);
    // runaway limit of two cycles with its auto mute
    wr(IX_WD_LO, 32'h2);
    wr(IX_WD_EN, 32'h1);
    wr(IX_MUTE, 32'h1);
    frame(10, n);
    check("wd_flag", {31'h0, err_flags.wd}, 32'h1);
    check("wd_mute", {31'h0, core_mute}, 32'h1);
    frame(10, n);
    check("wd_hold", {31'h0, core_mute}, 32'h1);
    exp_mem[IX_WD_ERR] = 32'h1;
    rd("wd_reg", IX_WD_ERR);
    wr(IX_WD_EN, 32'h0);
    exp_mem[IX_WD_ERR] = 32'h0;
    repeat (3) @(posedge clock);
    check("wd_clear", {31'h0, err_flags.wd}, 32'h0);
    check("wd_unmute", {31'h0, core_mute}, 32'h0);
    // halt with a small level and watch it step to zero
    rnd = 1'b0;
    repeat (3) @(posedge clock);
    wr(IX_RUN, 32'h0);
    for (int k = 0; k < 8 && core_mute !== 1'b1; k++) @(posedge clock);
    @(posedge clock);
    // sample after the edge has settled so each step is seen exactly once
    #1;
    repeat (6) begin
      a = audio_out;
      @(posedge clock);
      #1 check("slew", {8'h0, audio_out}, a > 24'h100 ? {8'h0, a - 24'h100} : 32'h0);
    end
    check("halt_mute", {31'h0, core_mute}, 32'h1);
    wr(IX_RUN, 32'h1);
    // checksum against a random upper ideal half, compared every 4096 frames
    wr(IX_MUTE, 32'h2);
    wr(IX_CRC_HI, $urandom);
    rd("crc_hi", IX_CRC_HI);
    wr(IX_CRC_EN, 32'h1);
    for (int i = 0; i < 4200 && err_flags.crc !== 1'b1; i++) frame(6, n);
    repeat (2) @(posedge clock);
    check("crc_flag", {31'h0, err_flags.crc}, 32'h1);
    check("crc_mute", {31'h0, core_mute}, 32'h1);
    wr(IX_CRC_EN, 32'h0);
    repeat (3) @(posedge clock);
    check("crc_clear", {31'h0, err_flags.crc}, 32'h0);
    print_verdict();
  end
endmodule
